//--- include/pwrsel_regs.vh
// Event codes, selector values and limits of the power unit event decoder
`ifndef PWRSEL_REGS_VH
`define PWRSEL_REGS_VH

`define PWRSEL_CODE_W 8
`define PWRSEL_INC_W 4
`define PWRSEL_CORES 15
`define PWRSEL_OCC_W 4
`define PWRSEL_OCC_MAX 4'h8
`define PWRSEL_BAND_W 8

// Unit clock: fixed 800 MHz reference, sampled here at 40 MHz
`define PWRSEL_UNIT_CLK_MHZ 800
`define PWRSEL_CLK_MHZ 40

// Events with the extra select bit clear
`define PWRSEL_EV_CLOCKS 8'h00
`define PWRSEL_EV_VOLT_UP 8'h01
`define PWRSEL_EV_VOLT_DOWN 8'h02
`define PWRSEL_EV_VOLT_CHANGE 8'h03
`define PWRSEL_EV_THERM_UPPER 8'h04
`define PWRSEL_EV_POWER_UPPER 8'h05
`define PWRSEL_EV_OS_UPPER 8'h06
`define PWRSEL_EV_CURR_UPPER 8'h07
`define PWRSEL_EV_HOT_INT 8'h09
`define PWRSEL_EV_HOT_EXT 8'h0a
`define PWRSEL_EV_BAND0 8'h0b
`define PWRSEL_EV_BAND3 8'h0e
`define PWRSEL_EV_DEMOTE_LO 8'h1e
`define PWRSEL_EV_DEMOTE_LO_END 8'h25
`define PWRSEL_EV_MEM_SHED 8'h2f
`define PWRSEL_EV_VR_HOT 8'h32
`define PWRSEL_EV_DEMOTE_HI 8'h40
`define PWRSEL_EV_DEMOTE_HI_END 8'h46
`define PWRSEL_EV_FREQ_TRANS 8'h60
`define PWRSEL_EV_IO_LOWER 8'h61
`define PWRSEL_EV_ALL_TRANS 8'h63
`define PWRSEL_EV_CORE_TRANS 8'h70
`define PWRSEL_EV_CORE_TRANS_END 8'h7e
`define PWRSEL_EV_OCCUPANCY 8'h80

// Events with the extra select bit set
`define PWRSEL_XEV_PERF_LOWER 8'h02
`define PWRSEL_XEV_REJECT 8'h17
`define PWRSEL_XEV_REJECT_END 8'h25
`define PWRSEL_XEV_PKG_EXIT 8'h26

// Demotion index offset for the upper code group (cores 8 to 14)
`define PWRSEL_DEMOTE_HI_CORE 8'h08

// Occupancy selector values
`define PWRSEL_OCC_C0 2'h1
`define PWRSEL_OCC_C3 2'h2
`define PWRSEL_OCC_C6 2'h3

// Per-core state encoding on the core state input
`define PWRSEL_CST_C0 2'h0
`define PWRSEL_CST_C3 2'h1
`define PWRSEL_CST_C6 2'h2

`endif

//--- logic/pwrsel_dec.v
// Combinational event decoder for one counter
`include "pwrsel_regs.vh"

module pwrsel_dec (
    input wire [7:0] code_i,       // Event code
    input wire xsel_i,             // Extra select bit
    input wire [1:0] occ_sel_i,    // Occupancy selector
    input wire en_i,               // Counter enabled
    input wire [15:0] cond_i,      // Single conditions, see top
    input wire [3:0] band_hit_i,   // Band residency per band
    input wire [14:0] demote_i,    // Per-core demotion pulses
    input wire [14:0] trans_i,     // Per-core transition levels
    input wire [14:0] reject_i,    // Per-core rejection pulses
    input wire [3:0] occ_c0_i,     // Cores in C0
    input wire [3:0] occ_c3_i,     // Cores in C3
    input wire [3:0] occ_c6_i,     // Cores in C6
    output reg [3:0] inc_o         // Increment this cycle
);

    // Picks one core bit by code offset from a group base
    function pick;
        input [14:0] vec;
        input [7:0] code;
        input [7:0] base;
        reg [7:0] idx;
        begin
            idx = code - base;
            pick = (idx < 8'd15) ? vec[idx[3:0]] : 1'b0;
        end
    endfunction

    function in_range;
        input [7:0] code;
        input [7:0] lo;
        input [7:0] hi;
        begin
            in_range = (code >= lo) && (code <= hi);
        end
    endfunction

    reg hit;
    reg [3:0] occ;

    always @* begin
        hit = 1'b0;
        occ = 4'h0;
        inc_o = 4'h0;
        if (!xsel_i) begin
            case (code_i)
                `PWRSEL_EV_CLOCKS: hit = 1'b1;
                `PWRSEL_EV_VOLT_UP: hit = cond_i[0];
                `PWRSEL_EV_VOLT_DOWN: hit = cond_i[1];
                `PWRSEL_EV_VOLT_CHANGE: hit = cond_i[0] | cond_i[1];
                `PWRSEL_EV_THERM_UPPER: hit = cond_i[2];
                `PWRSEL_EV_POWER_UPPER: hit = cond_i[3];
                `PWRSEL_EV_OS_UPPER: hit = cond_i[4];
                `PWRSEL_EV_CURR_UPPER: hit = cond_i[5];
                `PWRSEL_EV_HOT_INT: hit = cond_i[6];
                `PWRSEL_EV_HOT_EXT: hit = cond_i[7];
                `PWRSEL_EV_MEM_SHED: hit = cond_i[8];
                `PWRSEL_EV_VR_HOT: hit = cond_i[9];
                `PWRSEL_EV_FREQ_TRANS: hit = cond_i[10];
                `PWRSEL_EV_IO_LOWER: hit = cond_i[11];
                `PWRSEL_EV_ALL_TRANS: hit = |trans_i;
                `PWRSEL_EV_OCCUPANCY: begin
                    case (occ_sel_i)
                        `PWRSEL_OCC_C0: occ = occ_c0_i;
                        `PWRSEL_OCC_C3: occ = occ_c3_i;
                        `PWRSEL_OCC_C6: occ = occ_c6_i;
                        default: occ = 4'h0;
                    endcase
                end
                default: begin
                    if (in_range(code_i, `PWRSEL_EV_BAND0, `PWRSEL_EV_BAND3)) begin
                        hit = band_hit_i[code_i[1:0] - 2'h3];
                    end else if (in_range(code_i, `PWRSEL_EV_DEMOTE_LO,
                                          `PWRSEL_EV_DEMOTE_LO_END)) begin
                        hit = pick(demote_i, code_i, `PWRSEL_EV_DEMOTE_LO);
                    end else if (in_range(code_i, `PWRSEL_EV_DEMOTE_HI,
                                          `PWRSEL_EV_DEMOTE_HI_END)) begin
                        hit = pick(demote_i, code_i + `PWRSEL_DEMOTE_HI_CORE,
                                   `PWRSEL_EV_DEMOTE_HI);
                    end else if (in_range(code_i, `PWRSEL_EV_CORE_TRANS,
                                          `PWRSEL_EV_CORE_TRANS_END)) begin
                        hit = pick(trans_i, code_i, `PWRSEL_EV_CORE_TRANS);
                    end else begin
                        hit = 1'b0;
                    end
                end
            endcase
        end else begin
            // Same code values decode to a separate event space
            case (code_i)
                `PWRSEL_XEV_PERF_LOWER: hit = cond_i[12];
                `PWRSEL_XEV_PKG_EXIT: hit = cond_i[13];
                default: begin
                    if (in_range(code_i, `PWRSEL_XEV_REJECT, `PWRSEL_XEV_REJECT_END)) begin
                        hit = pick(reject_i, code_i, `PWRSEL_XEV_REJECT);
                    end else begin
                        hit = 1'b0;
                    end
                end
            endcase
        end
        if (en_i) begin
            inc_o = (occ > `PWRSEL_OCC_MAX) ? `PWRSEL_OCC_MAX : (occ | {3'h0, hit});
        end
    end

endmodule

//--- logic/pwrsel_top.v
// Event selection decoder for the four power unit performance counters
`include "pwrsel_regs.vh"

module pwrsel_top (
    input wire CLK_I,              // 40 MHz clock
    input wire SRST_I,             // Synchronous reset, active high
    input wire CE_I,               // Clock enable, freezes state when low
    input wire [7:0] EVT_SEL0_I,   // Counter 0 event code
    input wire [7:0] EVT_SEL1_I,   // Counter 1 event code
    input wire [7:0] EVT_SEL2_I,   // Counter 2 event code
    input wire [7:0] EVT_SEL3_I,   // Counter 3 event code
    input wire [3:0] XSEL_I,       // Extra select bit per counter
    input wire [1:0] OCC_SEL0_I,   // Counter 0 occupancy selector
    input wire [1:0] OCC_SEL1_I,   // Counter 1 occupancy selector
    input wire [1:0] OCC_SEL2_I,   // Counter 2 occupancy selector
    input wire [1:0] OCC_SEL3_I,   // Counter 3 occupancy selector
    input wire [3:0] CNT_EN_I,     // Counter enable per counter
    input wire [31:0] BAND_THR_I,  // Band thresholds, band 0 in 7:0
    input wire [7:0] FREQ_RATIO_I, // Current frequency ratio
    input wire VOLT_UP_I,          // Voltage increasing
    input wire VOLT_DOWN_I,        // Voltage decreasing
    input wire THERM_UPPER_I,      // Thermal is strongest upper limit
    input wire POWER_UPPER_I,      // Power is strongest upper limit
    input wire OS_UPPER_I,         // OS request is strongest upper limit
    input wire CURR_UPPER_I,       // Current is strongest upper limit
    input wire HOT_INT_I,          // Internal hot throttle
    input wire HOT_EXT_I,          // External hot throttle
    input wire MEM_SHED_I,         // Memory regulator phase shedding
    input wire VR_HOT_I,           // Regulator hot
    input wire FREQ_TRANS_I,       // Frequency change in progress
    input wire IO_LOWER_I,         // IO limit is strongest lower limit
    input wire PERF_LOWER_I,       // Perf limit is strongest lower limit
    input wire PKG_EXIT_I,         // Package sleep exit in progress
    input wire [14:0] DEMOTE_I,    // Per-core demotion pulse
    input wire [14:0] CORE_TRANS_I,// Per-core C-state transition level
    input wire [14:0] REJECT_I,    // Per-core deep sleep rejection pulse
    input wire [29:0] CORE_CST_I,  // Per-core state, two bits each
    output wire [3:0] INC0_O,      // Counter 0 increment
    output wire [3:0] INC1_O,      // Counter 1 increment
    output wire [3:0] INC2_O,      // Counter 2 increment
    output wire [3:0] INC3_O       // Counter 3 increment
);

    ////////////////////////////////////////////////////////////////////////
    // Occupancy tally
    ////////////////////////////////////////////////////////////////////////

    // Number of cores whose state equals the given value
    function [3:0] tally;
        input [29:0] cst;
        input [1:0] want;
        integer k;
        reg [3:0] n;
        begin
            n = 4'h0;
            for (k = 0; k < `PWRSEL_CORES; k = k + 1) begin
                if (cst[2*k +: 2] == want) begin
                    n = n + 4'h1;
                end
            end
            tally = n;
        end
    endfunction

    wire [3:0] occ_c0 = tally(CORE_CST_I, `PWRSEL_CST_C0);
    wire [3:0] occ_c3 = tally(CORE_CST_I, `PWRSEL_CST_C3);
    wire [3:0] occ_c6 = tally(CORE_CST_I, `PWRSEL_CST_C6);

    ////////////////////////////////////////////////////////////////////////
    // Band residency
    ////////////////////////////////////////////////////////////////////////

    // Each band checks the ratio against its own threshold byte
    wire [3:0] band_hit;

    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1) begin : g_band
            assign band_hit[b] = FREQ_RATIO_I >= BAND_THR_I[8*b +: 8];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Condition vector
    ////////////////////////////////////////////////////////////////////////

    wire [15:0] cond = {
        2'h0,
        PKG_EXIT_I,
        PERF_LOWER_I,
        IO_LOWER_I,
        FREQ_TRANS_I,
        VR_HOT_I,
        MEM_SHED_I,
        HOT_EXT_I,
        HOT_INT_I,
        CURR_UPPER_I,
        OS_UPPER_I,
        POWER_UPPER_I,
        THERM_UPPER_I,
        VOLT_DOWN_I,
        VOLT_UP_I
    };

    wire [31:0] code_all = {EVT_SEL3_I, EVT_SEL2_I, EVT_SEL1_I, EVT_SEL0_I};
    wire [7:0] occ_all = {OCC_SEL3_I, OCC_SEL2_I, OCC_SEL1_I, OCC_SEL0_I};
    wire [15:0] inc_all;

    ////////////////////////////////////////////////////////////////////////
    // Per-counter decoders
    ////////////////////////////////////////////////////////////////////////

    // Identical decoder on every counter
    genvar c;
    generate
        for (c = 0; c < 4; c = c + 1) begin : g_ctr
            pwrsel_dec u_dec (
                .code_i(code_all[8*c +: 8]),
                .xsel_i(XSEL_I[c]),
                .occ_sel_i(occ_all[2*c +: 2]),
                .en_i(CNT_EN_I[c]),
                .cond_i(cond),
                .band_hit_i(band_hit),
                .demote_i(DEMOTE_I),
                .trans_i(CORE_TRANS_I),
                .reject_i(REJECT_I),
                .occ_c0_i(occ_c0),
                .occ_c3_i(occ_c3),
                .occ_c6_i(occ_c6),
                .inc_o(inc_all[4*c +: 4])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Output registers
    ////////////////////////////////////////////////////////////////////////

    reg [15:0] inc_ff;
    wire [15:0] nxt_inc = inc_all;

    always @(posedge CLK_I) begin
        if (SRST_I) begin
            inc_ff <= 16'h0000;
        end else if (CE_I) begin
            inc_ff <= nxt_inc;
        end
    end

    assign INC0_O = inc_ff[3:0];
    assign INC1_O = inc_ff[7:4];
    assign INC2_O = inc_ff[11:8];
    assign INC3_O = inc_ff[15:12];

endmodule

//--- bench/pwrsel_top_props.sv
// Port checks on the event decoder
module pwrsel_top_props (
    input wire CLK_I,              // Clock
    input wire SRST_I,             // Reset
    input wire CE_I,               // Clock enable
    input wire [7:0] EVT_SEL0_I,   // Code 0
    input wire [7:0] EVT_SEL1_I,   // Code 1
    input wire [7:0] EVT_SEL2_I,   // Code 2
    input wire [7:0] EVT_SEL3_I,   // Code 3
    input wire [3:0] XSEL_I,       // Extra select
    input wire [1:0] OCC_SEL0_I,   // Occupancy 0
    input wire [3:0] CNT_EN_I,     // Enables
    input wire THERM_UPPER_I,      // Thermal limit
    input wire MEM_SHED_I,         // Phase shedding
    input wire PERF_LOWER_I,       // Perf limit
    input wire PKG_EXIT_I,         // Package exit
    input wire [14:0] CORE_TRANS_I,// Transitions
    input wire [3:0] INC0_O,       // Increment 0
    input wire [3:0] INC1_O,       // Increment 1
    input wire [3:0] INC2_O,       // Increment 2
    input wire [3:0] INC3_O        // Increment 3
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge CLK_I);
    endclocking
    default disable iff (SRST_I);
    wire run0 = CE_I && CNT_EN_I[0];

    chk_therm_follow: assert property (
        run0 && EVT_SEL0_I == 8'h04 && !XSEL_I[0] |=> INC0_O == {3'h0, $past(THERM_UPPER_I)})
        else $error("thermal limit count wrong");
    chk_perf_extra: assert property (
        run0 && EVT_SEL0_I == 8'h02 && XSEL_I[0] |=> INC0_O == {3'h0, $past(PERF_LOWER_I)})
        else $error("perf limit count wrong");
    chk_pkg_exit: assert property (
        CE_I && CNT_EN_I[1] && EVT_SEL1_I == 8'h26 && XSEL_I[1]
        |=> INC1_O == {3'h0, $past(PKG_EXIT_I)}) else $error("package exit count wrong");
    chk_mem_shed: assert property (
        CE_I && CNT_EN_I[2] && EVT_SEL2_I == 8'h2f && !XSEL_I[2]
        |=> INC2_O == {3'h0, $past(MEM_SHED_I)}) else $error("shedding count wrong");
    chk_all_trans: assert property (
        CE_I && CNT_EN_I[3] && EVT_SEL3_I == 8'h63 && !XSEL_I[3]
        |=> INC3_O == {3'h0, $past(|CORE_TRANS_I)}) else $error("total transition wrong");
    chk_unassigned_zero: assert property (
        run0 && EVT_SEL0_I == 8'h08 |=> INC0_O == 4'h0) else $error("unassigned code counted");
    chk_disabled_zero: assert property (
        CE_I && !CNT_EN_I[0] |=> INC0_O == 4'h0) else $error("disabled counter counted");
    chk_clock_count: assert property (
        CE_I && CNT_EN_I[2] && EVT_SEL2_I == 8'h00 && !XSEL_I[2] |=> INC2_O == 4'h1)
        else $error("clock count wrong");
    chk_occ_none: assert property (
        run0 && EVT_SEL0_I == 8'h80 && OCC_SEL0_I == 2'h0 |=> INC0_O == 4'h0)
        else $error("empty occupancy selector counted");
    chk_max_inc: assert property (
        INC0_O <= 4'h8 && INC1_O <= 4'h8 && INC2_O <= 4'h8 && INC3_O <= 4'h8)
        else $error("increment above eight");

    cover property (run0 && EVT_SEL0_I == 8'h80 ##1 INC0_O == 4'h8);
    cover property (run0 && XSEL_I[0] && EVT_SEL0_I == 8'h02 ##1 INC0_O == 4'h1);
    cover property (!CE_I ##1 !CE_I);
endmodule

bind pwrsel_top pwrsel_top_props i_pwrsel_top_props (
    .CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(CE_I), .EVT_SEL0_I(EVT_SEL0_I),
    .EVT_SEL1_I(EVT_SEL1_I), .EVT_SEL2_I(EVT_SEL2_I), .EVT_SEL3_I(EVT_SEL3_I),
    .XSEL_I(XSEL_I), .OCC_SEL0_I(OCC_SEL0_I), .CNT_EN_I(CNT_EN_I),
    .THERM_UPPER_I(THERM_UPPER_I), .MEM_SHED_I(MEM_SHED_I), .PERF_LOWER_I(PERF_LOWER_I),
    .PKG_EXIT_I(PKG_EXIT_I), .CORE_TRANS_I(CORE_TRANS_I), .INC0_O(INC0_O),
    .INC1_O(INC1_O), .INC2_O(INC2_O), .INC3_O(INC3_O)
);

//--- bench/pwrsel_pm_model.sv
// Power management and core state source model
module pwrsel_pm_model (
    input wire logic [7:0] pick_i, // Source to raise, ff none
    input wire logic [1:0] st_i,   // State of occupied cores
    input wire logic [3:0] n_i,    // Number of occupied cores
    output logic [13:0] cond_o,    // Condition levels
    output logic [14:0] dem_o,     // Demotion pulses
    output logic [14:0] trn_o,     // Transition levels
    output logic [14:0] rej_o,     // Rejection pulses
    output logic [29:0] cst_o      // Core states
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////
    // Demotion pulses last one cycle; the bench repeats each rejection pick, so those last two
    always_comb begin
        cond_o = 14'h0;
        dem_o = 15'h0;
        trn_o = 15'h0;
        rej_o = 15'h0;
        if (pick_i < 8'h0e) begin
            cond_o[pick_i[3:0]] = 1'b1;
        end
        case (pick_i[7:4])
            4'h2: dem_o[pick_i[3:0]] = 1'b1;
            4'h4: trn_o[pick_i[3:0]] = 1'b1;
            4'h6: rej_o[pick_i[3:0]] = 1'b1;
            default: ;
        endcase
        // Cores beyond the count sit in the other state
        for (int k = 0; k < 15; k++) begin
            cst_o[2*k +: 2] = (k < n_i) ? st_i : 2'h3;
        end
    end
endmodule

//--- bench/pwrsel_top_tb.sv
// Self-checking bench for the event decoder
module pwrsel_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] sel [4] = '{default: 8'h0};
    logic [3:0] xs = 4'h0;
    logic [1:0] occ = 2'h0;
    logic [3:0] en = 4'hf;
    logic [31:0] thr = 32'h0;
    logic [7:0] ratio = 8'h0;
    logic [7:0] pick = 8'hff;
    logic [1:0] st = 2'h0;
    logic [3:0] n = 4'h0;
    logic [7:0] c;
    logic [13:0] cond;
    logic [14:0] dem;
    logic [14:0] trn;
    logic [14:0] rej;
    logic [29:0] cst;
    logic [3:0] inc [4];
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    // Rows: code, extra bit, source picked, expected increment
    logic [23:0] rows [23] = '{
        24'h040021, 24'h040030, 24'h050031, 24'h060041, 24'h070051,
        24'h2f0081, 24'h6100b1, 24'h6100c0, 24'h0210c1, 24'h0200c0,
        24'h021010, 24'h2610d1, 24'h030001, 24'h030011, 24'h041020,
        24'h080020, 24'h000ff1,
        24'h090061, 24'h0a0071, 24'h320091, 24'h6000a1, 24'h010001, 24'h010010
    };

    always #12.5 clk = ~clk;

    pwrsel_top i_pwrsel_top (
        .CLK_I(clk), .SRST_I(srst), .CE_I(ce), .EVT_SEL0_I(sel[0]), .EVT_SEL1_I(sel[1]),
        .EVT_SEL2_I(sel[2]), .EVT_SEL3_I(sel[3]), .XSEL_I(xs), .OCC_SEL0_I(occ),
        .OCC_SEL1_I(occ), .OCC_SEL2_I(occ), .OCC_SEL3_I(occ), .CNT_EN_I(en),
        .BAND_THR_I(thr), .FREQ_RATIO_I(ratio), .VOLT_UP_I(cond[0]), .VOLT_DOWN_I(cond[1]),
        .THERM_UPPER_I(cond[2]), .POWER_UPPER_I(cond[3]), .OS_UPPER_I(cond[4]),
        .CURR_UPPER_I(cond[5]), .HOT_INT_I(cond[6]), .HOT_EXT_I(cond[7]),
        .MEM_SHED_I(cond[8]), .VR_HOT_I(cond[9]), .FREQ_TRANS_I(cond[10]),
        .IO_LOWER_I(cond[11]), .PERF_LOWER_I(cond[12]), .PKG_EXIT_I(cond[13]),
        .DEMOTE_I(dem), .CORE_TRANS_I(trn), .REJECT_I(rej), .CORE_CST_I(cst),
        .INC0_O(inc[0]), .INC1_O(inc[1]), .INC2_O(inc[2]), .INC3_O(inc[3])
    );

    pwrsel_pm_model i_pwrsel_pm_model (
        .pick_i(pick), .st_i(st), .n_i(n), .cond_o(cond), .dem_o(dem), .trn_o(trn),
        .rej_o(rej), .cst_o(cst)
    );

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // One cycle of a selection on all four counters
    task automatic run(input logic [7:0] cd, input logic x, input logic [7:0] p,
                       input logic [3:0] e);
        sel = '{cd, cd, cd, cd};
        xs = {4{x}};
        pick = p;
        @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            chk($sformatf("inc%0d code %h", i, cd), e, inc[i]);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge clk);
        chk("reset", 4'h0, inc[0]);
        srst = 1'b0;
        foreach (rows[r]) begin
            run(rows[r][23:16], rows[r][12], rows[r][11:4], rows[r][3:0]);
        end
        for (int k = 0; k < 15; k++) begin
            c = (k < 8) ? 8'h1e + 8'(k) : 8'h38 + 8'(k);
            run(c, 1'b0, 8'h20 + 8'(k), 4'h1);
            run(c, 1'b0, 8'h20 + 8'((k + 1) % 15), 4'h0);
            run(8'h70 + 8'(k), 1'b0, 8'h40 + 8'(k), 4'h1);
            run(8'h70 + 8'(k), 1'b0, 8'h40 + 8'((k + 1) % 15), 4'h0);
            run(8'h63, 1'b0, 8'h40 + 8'(k), 4'h1);
            run(8'h17 + 8'(k), 1'b1, 8'h60 + 8'(k), 4'h1);
            run(8'h17 + 8'(k), 1'b0, 8'h60 + 8'(k), 4'h0);
        end
        for (int s = 0; s < 4; s++) begin
            for (int m = 0; m < 15; m += 5) begin
                occ = 2'(s);
                st = (s == 0) ? 2'h0 : 2'(s - 1);
                n = 4'(m);
                run(8'h80, 1'b0, 8'hff, (s == 0) ? 4'h0 : (m > 8) ? 4'h8 : 4'(m));
            end
        end
        thr = 32'h40302010;
        for (int b = 0; b < 4; b++) begin
            ratio = 8'h10 + 8'(16 * b);
            run(8'h0b + 8'(b), 1'b0, 8'hff, 4'h1);
            ratio = ratio - 8'h01;
            run(8'h0b + 8'(b), 1'b0, 8'hff, 4'h0);
        end
        // Counters on different events stay apart
        sel = '{8'h04, 8'h05, 8'h06, 8'h07};
        xs = 4'h0;
        pick = 8'h02;
        en = 4'ha;
        @(negedge clk);
        chk("off0", 4'h0, inc[0]);
        chk("pow1", 4'h0, inc[1]);
        chk("off2", 4'h0, inc[2]);
        en = 4'hf;
        @(negedge clk);
        chk("therm0", 4'h1, inc[0]);
        ce = 1'b0;
        pick = 8'hff;
        repeat (3) @(negedge clk);
        chk("frozen", 4'h1, inc[0]);
        ce = 1'b1;
        @(negedge clk);
        chk("thawed", 4'h0, inc[0]);
        sel = '{default: 8'h0};
        srst = 1'b1;
        @(negedge clk);
        chk("midreset", 4'h0, inc[2]);
        srst = 1'b0;
        @(negedge clk);
        chk("restart", 4'h1, inc[2]);
        report_and_stop();
    end
endmodule
